// file: rtl/smc_ctrl.v
// Modem command mode controller: AT parser, call sequencer, data path
// Behaviour
// - After reset the controller starts in offline command mode.
// - Command mode collects serial characters and executes each complete valid line.
// - Commands: answer, dial, hook on/off, S-register read/write, direct chip write.
// - Dial or answer rewrites chip registers with controller settings.
// - Call runs dialling, call progress detection, then negotiation in order.
// - Any host character during negotiation aborts the attempt.
// - In offline command mode with non-zero ring count, chip status is polled every 20 ms.
// - After the set number of rings the call is answered automatically.
// - Successful negotiation enters data transfer mode.
// - Data mode forwards host bytes to line and line bytes to host.
// - Three plus signs in data mode enter online command mode, call kept.
// - Hang-up command goes on-hook and ends the connection.
// - Online command mode takes commands; return-online resumes data mode.
// - Host serial link runs at a fixed 19200 bit/s.
// - Host flow is paced by clear-to-send so the buffer never overflows.
// - Chip gain comes from S25 captured at call start; chip mode is set by dial or answer.
// - Gain changes made online are ignored until the next call.
`include "smc_map.vh"
`default_nettype none

module smc_ctrl #(
  parameter [18:0] POLL_CYCLES = `SMC_POLL_CYC
) (
  input  wire       mclk,
  input  wire       sys_rst,
  input  wire       host_rxd,
  input  wire       host_rts,
  output reg        host_txd,
  output reg        host_cts,
  output reg        host_dcd,
  output reg        off_hook,
  output reg        mode_data,
  output reg  [7:0] line_tx_data,
  output reg        line_tx_valid,
  input  wire       line_tx_ready,
  input  wire [7:0] line_rx_data,
  input  wire       line_rx_valid,
  output reg        line_rx_ready,
  output reg        chip_wr,
  output reg  [7:0] chip_addr,
  output reg  [7:0] chip_data,
  output reg        chip_stat_rd,
  input  wire       chip_ring,
  output reg  [1:0] chip_phase,
  output reg        chip_phase_start,
  input  wire       chip_phase_done,
  input  wire       chip_phase_fail
);

  localparam [31:0] BIT_FULL = `SMC_BIT_CYC;
  localparam [10:0] BIT_CYC  = BIT_FULL[10:0];
  localparam [10:0] HALF_CYC = BIT_CYC >> 1;

  function [4:0] hexv;
    input [7:0] c;
    begin
      if (c >= `SMC_CH_0 && c <= 8'h39) hexv = {1'b1, c[3:0]};
      else if (c >= 8'h41 && c <= 8'h46) hexv = {1'b1, c[3:0] + 4'h9};
      else hexv = 5'h00;
    end
  endfunction

  function [7:0] hexa;
    input [3:0] n;
    begin
      hexa = (n < 4'ha) ? {4'h3, n} : {4'h4, n - 4'h9};
    end
  endfunction

  // ----------------------------------------
  // Host receiver, 8N1
  // ----------------------------------------
  reg [10:0] rx_cnt_reg;
  reg [3:0]  rx_bit_reg;
  reg [7:0]  rx_sh_reg;
  reg        rx_busy_reg;
  reg [7:0]  rx_byte_reg;
  reg        rx_stb_reg;

  always @(posedge mclk) begin
    if (sys_rst) begin
      rx_cnt_reg  <= 11'h000;
      rx_bit_reg  <= 4'h0;
      rx_sh_reg   <= 8'h00;
      rx_busy_reg <= 1'b0;
      rx_byte_reg <= 8'h00;
      rx_stb_reg  <= 1'b0;
    end else begin
      rx_stb_reg <= 1'b0;
      if (!rx_busy_reg) begin
        if (!host_rxd) begin
          rx_busy_reg <= 1'b1;
          rx_cnt_reg  <= HALF_CYC;
          rx_bit_reg  <= 4'h0;
        end
      end else if (rx_cnt_reg != 11'h000) begin
        rx_cnt_reg <= rx_cnt_reg - 11'h001;
      end else begin
        rx_cnt_reg <= BIT_CYC - 11'h001;
        rx_bit_reg <= rx_bit_reg + 4'h1;
        if (rx_bit_reg == 4'h0 && host_rxd) begin
          rx_busy_reg <= 1'b0;
        end else if (rx_bit_reg == 4'h9) begin
          rx_busy_reg <= 1'b0;
          rx_byte_reg <= rx_sh_reg;
          rx_stb_reg  <= host_rxd;
        end else if (rx_bit_reg != 4'h0) begin
          rx_sh_reg <= {host_rxd, rx_sh_reg[7:1]};
        end
      end
    end
  end

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  reg [6:0] st_reg;
  reg [7:0] lb_reg [0:7];
  reg [3:0] idx_reg;
  reg       ovf_reg;
  reg       exec_reg;
  reg [7:0] s0_reg;
  reg [7:0] s25_reg;
  reg [7:0] gain_cap_reg;
  reg       orig_reg;
  reg       cfg_step_reg;
  reg [18:0] poll_cnt_reg;
  reg       ring_prev_reg;
  reg [7:0] ring_n_reg;
  reg [7:0] reply_reg;
  reg       reply_pend_reg;
  reg [1:0] esc_cnt_reg;
  reg [7:0] fq_reg [0:1];
  reg       fw_reg;
  reg       fr_reg;
  reg [1:0] fcnt_reg;
  reg        tx_busy_reg;
  reg [10:0] tx_cnt_reg;
  reg [3:0]  tx_bit_reg;
  reg [9:0]  tx_sh_reg;
  wire       tx_reply = reply_pend_reg && !tx_busy_reg && host_rts;

  wire [7:0] rx_up = (rx_byte_reg >= 8'h61 && rx_byte_reg <= 8'h7a) ?
                     rx_byte_reg - 8'h20 : rx_byte_reg;
  wire st_cmd   = st_reg == `SMC_ST_CMD;
  wire st_ol    = st_reg == `SMC_ST_OLCMD;
  wire in_cmd   = st_cmd | st_ol;
  wire [7:0] c2 = lb_reg[2];
  wire [7:0] c3 = lb_reg[3];
  wire [7:0] c4 = lb_reg[4];
  wire [7:0] c5 = lb_reg[5];
  wire [7:0] c6 = lb_reg[6];
  wire [4:0] h3 = hexv(c3);
  wire [4:0] h4 = hexv(c4);
  wire [4:0] h5 = hexv(c5);
  wire [4:0] h6 = hexv(c6);
  // Overlong lines and lines without the prefix fall through unexecuted
  wire exec_ok  = exec_reg && !ovf_reg && idx_reg >= 4'h2 &&
                  lb_reg[0] == `SMC_CH_A && lb_reg[1] == `SMC_CH_T;
  wire c_ans    = exec_ok && idx_reg == 4'h3 && c2 == `SMC_CH_A;
  wire c_dial   = exec_ok && idx_reg >= 4'h3 && c2 == `SMC_CH_D;
  wire c_hook0  = exec_ok && c2 == `SMC_CH_H &&
                  (idx_reg == 4'h3 || (idx_reg == 4'h4 && c3 == `SMC_CH_0));
  wire c_hook1  = exec_ok && idx_reg == 4'h4 && c2 == `SMC_CH_H && c3 == `SMC_CH_1;
  wire c_online = exec_ok && idx_reg == 4'h3 && c2 == `SMC_CH_O;
  wire s0_sel   = c2 == `SMC_CH_S && c3 == `SMC_CH_0;
  wire s25_sel  = c2 == `SMC_CH_S && c3 == `SMC_CH_2 && c4 == `SMC_CH_5;
  wire c_s0w    = exec_ok && idx_reg == 4'h6 && s0_sel && c4 == `SMC_CH_EQ && h5[4];
  wire c_s0r    = exec_ok && idx_reg == 4'h5 && s0_sel && c4 == `SMC_CH_QM;
  wire c_s25w   = exec_ok && idx_reg == 4'h7 && s25_sel && c5 == `SMC_CH_EQ && h6[4];
  wire c_s25r   = exec_ok && idx_reg == 4'h6 && s25_sel && c5 == `SMC_CH_QM;
  wire c_chip   = exec_ok && idx_reg == 4'h7 && c2 == `SMC_CH_HASH &&
                  h3[4] && h4[4] && h5[4] && h6[4];

  wire ring_hit = st_cmd && s0_reg != 8'h00 && chip_stat_rd && chip_ring &&
                  !ring_prev_reg && (ring_n_reg + 8'h01) >= s0_reg;
  wire call_go  = st_cmd && (c_ans || c_dial || ring_hit);
  wire ph_st    = st_reg == `SMC_ST_DIAL || st_reg == `SMC_ST_CPTD ||
                  st_reg == `SMC_ST_NEGO;
  wire hang     = (in_cmd && c_hook0) ||
                  (ph_st && !chip_phase_start && chip_phase_fail) ||
                  (st_reg == `SMC_ST_NEGO && rx_stb_reg);
  wire push     = st_reg == `SMC_ST_DATA && rx_stb_reg && fcnt_reg != 2'h2;
  wire pop      = fcnt_reg != 2'h0 && (!line_tx_valid || line_tx_ready);
  wire line_take = line_rx_valid && line_rx_ready;
  // Third plus sign: data mode ends at the next edge
  wire esc_hit  = st_reg == `SMC_ST_DATA && rx_stb_reg && rx_byte_reg == `SMC_CH_PLUS &&
                  esc_cnt_reg == 2'h2;

  // ----------------------------------------
  // Controller sequencer
  // ----------------------------------------
  always @(posedge mclk) begin
    if (sys_rst) begin
      st_reg         <= `SMC_ST_CMD;
      idx_reg        <= 4'h0;
      ovf_reg        <= 1'b0;
      exec_reg       <= 1'b0;
      s0_reg         <= `SMC_S0_RST;
      s25_reg        <= `SMC_S25_RST;
      gain_cap_reg   <= `SMC_S25_RST;
      orig_reg       <= 1'b0;
      cfg_step_reg   <= 1'b0;
      poll_cnt_reg   <= 19'h00000;
      ring_prev_reg  <= 1'b0;
      ring_n_reg     <= 8'h00;
      reply_reg      <= 8'h00;
      reply_pend_reg <= 1'b0;
      esc_cnt_reg    <= 2'h0;
      fw_reg         <= 1'b0;
      fr_reg         <= 1'b0;
      fcnt_reg       <= 2'h0;
      off_hook       <= 1'b0;
      host_dcd       <= 1'b0;
      mode_data      <= 1'b0;
      host_cts       <= 1'b1;
      line_tx_data   <= 8'h00;
      line_tx_valid  <= 1'b0;
      chip_wr        <= 1'b0;
      chip_addr      <= 8'h00;
      chip_data      <= 8'h00;
      chip_stat_rd   <= 1'b0;
      chip_phase     <= `SMC_PH_IDLE;
      chip_phase_start <= 1'b0;
    end else begin
      chip_wr          <= 1'b0;
      chip_stat_rd     <= 1'b0;
      chip_phase_start <= 1'b0;
      exec_reg         <= 1'b0;
      if (rx_stb_reg && in_cmd) begin
        if (rx_up == `SMC_CH_CR) begin
          exec_reg <= 1'b1;
        end else if (rx_up == `SMC_CH_BS) begin
          if (idx_reg != 4'h0) idx_reg <= idx_reg - 4'h1;
        end else if (idx_reg == 4'h8) begin
          ovf_reg <= 1'b1;
        end else begin
          lb_reg[idx_reg[2:0]] <= rx_up;
          idx_reg <= idx_reg + 4'h1;
        end
      end
      if (exec_reg) begin
        idx_reg <= 4'h0;
        ovf_reg <= 1'b0;
      end
      // Settings writes are kept online; S25 is only captured for the chip at call start
      if (in_cmd && c_s0w) s0_reg <= {4'h0, h5[3:0]};
      if (in_cmd && c_s25w) s25_reg <= {4'h0, h6[3:0]};
      // A new reply outranks the clear of the one now leaving
      if (tx_reply && !line_take) reply_pend_reg <= 1'b0;
      if (in_cmd && (c_s0r || c_s25r)) begin
        reply_reg      <= hexa(c_s0r ? s0_reg[3:0] : s25_reg[3:0]);
        reply_pend_reg <= 1'b1;
      end
      if (in_cmd && c_chip) begin
        chip_wr   <= 1'b1;
        chip_addr <= {h3[3:0], h4[3:0]};
        chip_data <= {h5[3:0], h6[3:0]};
      end
      if (st_cmd && c_hook1) off_hook <= 1'b1;
      if (st_ol && c_online) begin
        st_reg    <= `SMC_ST_DATA;
        mode_data <= 1'b1;
      end

      // Ring polling only runs offline with auto-answer armed
      if (st_cmd && s0_reg != 8'h00) begin
        if (poll_cnt_reg == POLL_CYCLES - 19'h00001) begin
          poll_cnt_reg <= 19'h00000;
          chip_stat_rd <= 1'b1;
        end else begin
          poll_cnt_reg <= poll_cnt_reg + 19'h00001;
        end
        if (chip_stat_rd) begin
          ring_prev_reg <= chip_ring;
          if (chip_ring && !ring_prev_reg) ring_n_reg <= ring_n_reg + 8'h01;
        end
      end else begin
        poll_cnt_reg  <= 19'h00000;
        ring_prev_reg <= 1'b0;
        ring_n_reg    <= 8'h00;
      end

      if (call_go) begin
        st_reg       <= `SMC_ST_CFG;
        gain_cap_reg <= s25_reg;
        orig_reg     <= c_dial;
        cfg_step_reg <= 1'b0;
        off_hook     <= 1'b1;
        ring_n_reg   <= 8'h00;
      end

      case (st_reg)
        `SMC_ST_CFG: begin
          chip_wr      <= 1'b1;
          cfg_step_reg <= 1'b1;
          chip_addr    <= cfg_step_reg ? `SMC_CHIP_MODE : `SMC_CHIP_GAIN;
          chip_data    <= cfg_step_reg ? {7'h00, orig_reg} : gain_cap_reg;
          if (cfg_step_reg) begin
            st_reg           <= `SMC_ST_DIAL;
            chip_phase       <= `SMC_PH_DIAL;
            chip_phase_start <= 1'b1;
          end
        end
        `SMC_ST_DIAL: begin
          if (!chip_phase_start && chip_phase_done) begin
            st_reg           <= `SMC_ST_CPTD;
            chip_phase       <= `SMC_PH_CPTD;
            chip_phase_start <= 1'b1;
          end
        end
        `SMC_ST_CPTD: begin
          if (!chip_phase_start && chip_phase_done) begin
            st_reg           <= `SMC_ST_NEGO;
            chip_phase       <= `SMC_PH_NEGO;
            chip_phase_start <= 1'b1;
          end
        end
        `SMC_ST_NEGO: begin
          if (!chip_phase_start && chip_phase_done) begin
            st_reg      <= `SMC_ST_DATA;
            chip_phase  <= `SMC_PH_IDLE;
            host_dcd    <= 1'b1;
            mode_data   <= 1'b1;
            esc_cnt_reg <= 2'h0;
          end
        end
        `SMC_ST_DATA: begin
          // Plus signs are still forwarded; only the mode changes
          if (rx_stb_reg) begin
            if (rx_byte_reg != `SMC_CH_PLUS) begin
              esc_cnt_reg <= 2'h0;
            end else if (esc_cnt_reg == 2'h2) begin
              esc_cnt_reg <= 2'h0;
              st_reg      <= `SMC_ST_OLCMD;
              mode_data   <= 1'b0;
            end else begin
              esc_cnt_reg <= esc_cnt_reg + 2'h1;
            end
          end
        end
        default: begin
        end
      endcase

      // Host-to-line buffer, two entries
      if (push) begin
        fq_reg[fw_reg] <= rx_byte_reg;
        fw_reg         <= ~fw_reg;
      end
      if (line_tx_valid && line_tx_ready) line_tx_valid <= 1'b0;
      if (pop) begin
        line_tx_data  <= fq_reg[fr_reg];
        line_tx_valid <= 1'b1;
        fr_reg        <= ~fr_reg;
      end
      case ({push, pop})
        2'b10:   fcnt_reg <= fcnt_reg + 2'h1;
        2'b01:   fcnt_reg <= fcnt_reg - 2'h1;
        default: fcnt_reg <= fcnt_reg;
      endcase
      // One slot stays free for a byte already in flight when CTS drops
      host_cts <= (fcnt_reg == 2'h0 && !push) || (fcnt_reg == 2'h1 && pop && !push);

      if (hang) begin
        st_reg        <= `SMC_ST_CMD;
        off_hook      <= 1'b0;
        host_dcd      <= 1'b0;
        mode_data     <= 1'b0;
        chip_phase    <= `SMC_PH_IDLE;
        fcnt_reg      <= 2'h0;
        fw_reg        <= 1'b0;
        fr_reg        <= 1'b0;
        line_tx_valid <= 1'b0;
        host_cts      <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Host transmitter, line data or replies
  // ----------------------------------------
  always @(posedge mclk) begin
    if (sys_rst) begin
      tx_busy_reg   <= 1'b0;
      tx_cnt_reg    <= 11'h000;
      tx_bit_reg    <= 4'h0;
      tx_sh_reg     <= 10'h3ff;
      host_txd      <= 1'b1;
      line_rx_ready <= 1'b0;
    end else begin
      // Drops with the escape so no line byte is taken outside data mode
      line_rx_ready <= mode_data && !esc_hit && !tx_busy_reg && !line_take && host_rts;
      if (line_take || tx_reply) begin
        tx_busy_reg <= 1'b1;
        tx_cnt_reg  <= BIT_CYC - 11'h001;
        tx_bit_reg  <= 4'h0;
        tx_sh_reg   <= {1'b1, line_take ? line_rx_data : reply_reg, 1'b0};
        host_txd    <= 1'b0;
      end else if (tx_busy_reg) begin
        if (tx_cnt_reg != 11'h000) begin
          tx_cnt_reg <= tx_cnt_reg - 11'h001;
        end else begin
          tx_cnt_reg <= BIT_CYC - 11'h001;
          tx_bit_reg <= tx_bit_reg + 4'h1;
          tx_sh_reg  <= {1'b1, tx_sh_reg[9:1]};
          host_txd   <= tx_sh_reg[1];
          if (tx_bit_reg == 4'h9) begin
            tx_busy_reg <= 1'b0;
            host_txd    <= 1'b1;
          end
        end
      end
    end
  end

endmodule

`default_nettype wire

// file: rtl/smc_map.vh
// Constants for the modem command mode controller
`ifndef SMC_MAP_VH
`define SMC_MAP_VH
// ----------------------------------------
// Timing
// ----------------------------------------
`define SMC_CLK_KHZ     25000
`define SMC_BAUD        19200
`define SMC_BIT_CYC     ((`SMC_CLK_KHZ * 1000) / `SMC_BAUD)
`define SMC_POLL_MS     20
// Ring poll period in clocks, 20 ms at 25 MHz
`define SMC_POLL_CYC    19'h7a120
// ----------------------------------------
// Controller states, one-hot
// ----------------------------------------
`define SMC_ST_CMD      7'h01
`define SMC_ST_CFG      7'h02
`define SMC_ST_DIAL     7'h04
`define SMC_ST_CPTD     7'h08
`define SMC_ST_NEGO     7'h10
`define SMC_ST_DATA     7'h20
`define SMC_ST_OLCMD    7'h40
// ----------------------------------------
// Modem chip phases and registers
// ----------------------------------------
`define SMC_PH_IDLE     2'h0
`define SMC_PH_DIAL     2'h1
`define SMC_PH_CPTD     2'h2
`define SMC_PH_NEGO     2'h3
`define SMC_CHIP_GAIN   8'h01
`define SMC_CHIP_MODE   8'h02
// ----------------------------------------
// Characters
// ----------------------------------------
`define SMC_CH_A        8'h41
`define SMC_CH_T        8'h54
`define SMC_CH_D        8'h44
`define SMC_CH_H        8'h48
`define SMC_CH_O        8'h4f
`define SMC_CH_S        8'h53
`define SMC_CH_EQ       8'h3d
`define SMC_CH_QM       8'h3f
`define SMC_CH_HASH     8'h23
`define SMC_CH_PLUS     8'h2b
`define SMC_CH_CR       8'h0d
`define SMC_CH_BS       8'h08
`define SMC_CH_0        8'h30
`define SMC_CH_1        8'h31
`define SMC_CH_2        8'h32
`define SMC_CH_5        8'h35
`define SMC_S0_RST      8'h00
`define SMC_S25_RST     8'h00
`endif

// file: testbench/smc_ctrl_asserts.sv
// Port assertions for the modem command mode controller
`default_nettype none
module smc_ctrl_asserts #(
  parameter [18:0] POLL_CYCLES = 19'd500000
) (
  input wire logic       mclk,
  input wire logic       sys_rst,
  input wire logic       host_rxd,
  input wire logic       host_rts,
  input wire logic       host_txd,
  input wire logic       host_cts,
  input wire logic       host_dcd,
  input wire logic       off_hook,
  input wire logic       mode_data,
  input wire logic [7:0] line_tx_data,
  input wire logic       line_tx_valid,
  input wire logic       line_tx_ready,
  input wire logic [7:0] line_rx_data,
  input wire logic       line_rx_valid,
  input wire logic       line_rx_ready,
  input wire logic       chip_wr,
  input wire logic [7:0] chip_addr,
  input wire logic [7:0] chip_data,
  input wire logic       chip_stat_rd,
  input wire logic       chip_ring,
  input wire logic [1:0] chip_phase,
  input wire logic       chip_phase_start,
  input wire logic       chip_phase_done,
  input wire logic       chip_phase_fail
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  // ----------------------------------------
  // Mode, hook and call sequence
  // ----------------------------------------
  a_reset_offline:
    assert property (disable iff (1'b0) sys_rst |=> !mode_data && !off_hook && !host_dcd
      && host_cts && host_txd && chip_phase == 2'h0) else $error("not offline after reset");
  a_data_online:
    assert property (mode_data |-> host_dcd && off_hook && chip_phase == 2'h0)
    else $error("data mode without connection");
  a_dcd_hook:
    assert property (host_dcd |-> off_hook) else $error("connection shown while on-hook");
  a_phase_order:
    assert property ($changed(chip_phase) && chip_phase != 2'h0
      |-> chip_phase == $past(chip_phase) + 2'h1) else $error("call phase out of order");
  a_start_pulse:
    assert property (chip_phase_start |=> !chip_phase_start) else $error("start not a pulse");
  a_data_entry:
    assert property ($rose(mode_data) |-> $past(chip_phase) == 2'h3 || $past(host_dcd))
    else $error("data mode entered without negotiation");
  // ----------------------------------------
  // Data path
  // ----------------------------------------
  a_rx_gate:
    assert property (line_rx_ready |-> mode_data && host_rts) else $error("line taken offline");
  a_tx_hold:
    assert property (line_tx_valid && !line_tx_ready |=> line_tx_valid && $stable(line_tx_data))
    else $error("line byte dropped before acceptance");
  a_tx_online:
    assert property (line_tx_valid |-> host_dcd) else $error("line byte without connection");
  c_answer: cover property ($rose(mode_data));
  c_escape: cover property ($fell(mode_data) && host_dcd);
  c_line_rx: cover property (line_rx_valid && line_rx_ready);
endmodule

bind smc_ctrl smc_ctrl_asserts #(.POLL_CYCLES(POLL_CYCLES)) smc_ctrl_asserts_i (
  .mclk(mclk), .sys_rst(sys_rst), .host_rxd(host_rxd), .host_rts(host_rts),
  .host_txd(host_txd), .host_cts(host_cts), .host_dcd(host_dcd), .off_hook(off_hook),
  .mode_data(mode_data), .line_tx_data(line_tx_data), .line_tx_valid(line_tx_valid),
  .line_tx_ready(line_tx_ready), .line_rx_data(line_rx_data), .line_rx_valid(line_rx_valid),
  .line_rx_ready(line_rx_ready), .chip_wr(chip_wr), .chip_addr(chip_addr),
  .chip_data(chip_data), .chip_stat_rd(chip_stat_rd), .chip_ring(chip_ring),
  .chip_phase(chip_phase), .chip_phase_start(chip_phase_start),
  .chip_phase_done(chip_phase_done), .chip_phase_fail(chip_phase_fail));
`default_nettype wire

// file: testbench/smc_ctrl_tb_top.sv
// Testbench top for the modem command mode controller
`include "smc_map.vh"
`default_nettype none
module smc_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BIT = `SMC_BIT_CYC;
  logic        mclk, sys_rst, host_rxd, host_rts, host_txd, host_cts, host_dcd, off_hook;
  logic        mode_data, line_tx_valid, line_tx_ready, line_rx_valid, line_rx_ready;
  logic        chip_wr, chip_stat_rd, chip_ring, chip_phase_start, chip_phase_done;
  logic        chip_phase_fail;
  logic [7:0]  line_tx_data, line_rx_data, chip_addr, chip_data;
  logic [1:0]  chip_phase;
  logic [15:0] wr_q[$], lt_q[$];
  logic [1:0]  ph_q[$];
  int          fails, checked, cts_lo, polls;

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  smc_ctrl #(.POLL_CYCLES(19'd50)) smc_ctrl_i (
    .mclk(mclk), .sys_rst(sys_rst), .host_rxd(host_rxd), .host_rts(host_rts),
    .host_txd(host_txd), .host_cts(host_cts), .host_dcd(host_dcd), .off_hook(off_hook),
    .mode_data(mode_data), .line_tx_data(line_tx_data), .line_tx_valid(line_tx_valid),
    .line_tx_ready(line_tx_ready), .line_rx_data(line_rx_data), .line_rx_valid(line_rx_valid),
    .line_rx_ready(line_rx_ready), .chip_wr(chip_wr), .chip_addr(chip_addr),
    .chip_data(chip_data), .chip_stat_rd(chip_stat_rd), .chip_ring(chip_ring),
    .chip_phase(chip_phase), .chip_phase_start(chip_phase_start),
    .chip_phase_done(chip_phase_done), .chip_phase_fail(chip_phase_fail));

  smc_host_model smc_host_model_i (.mclk(mclk), .host_txd(host_txd), .host_cts(host_cts),
    .host_rxd(host_rxd), .host_rts(host_rts));

  // ----------------------------------------
  // Far-side responders and monitors
  // ----------------------------------------
  always @(posedge mclk) begin
    if (chip_wr === 1'b1) wr_q.push_back({chip_addr, chip_data});
    if (line_tx_valid === 1'b1 && line_tx_ready === 1'b1) lt_q.push_back({8'h00, line_tx_data});
    if (chip_phase_start === 1'b1) ph_q.push_back(chip_phase);
    if (host_cts === 1'b0) cts_lo++;
    if (chip_stat_rd === 1'b1) polls++;
  end
  // Line accepts every other cycle so held bytes are exercised
  always @(posedge mclk) begin
    #1 line_tx_ready = ~line_tx_ready;
  end
  initial begin
    forever begin
      @(posedge mclk);
      if (chip_phase_start === 1'b1) begin
        repeat (20) @(posedge mclk);
        #1 chip_phase_done = 1'b1;
        @(posedge mclk);
        #1 chip_phase_done = 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic send_str(input string s);
    for (int i = 0; i < s.len(); i++) smc_host_model_i.send_byte(s[i]);
  endtask
  task automatic test_reset;
    chk("idle outputs", 16'h0007,
      {10'h0, mode_data, off_hook, host_dcd, host_cts, host_txd, chip_phase == 2'h0});
    $display("test_reset done");
  endtask
  task automatic test_answer;
    send_str("ATA\r");
    for (int i = 0; i < 400 && mode_data !== 1'b1; i++) @(posedge mclk);
    #1;
    chk("gain write", {8'h01, `SMC_S25_RST}, wr_q[0]);
    chk("mode write", 16'h0200, wr_q[1]);
    chk("phase order", 16'h3123, {4'(ph_q.size()), 2'h0, ph_q[0], 2'h0, ph_q[1],
      2'h0, ph_q[2]});
    chk("connected", 16'h0007, {13'h0, mode_data, host_dcd, off_hook});
    chk("status polls", 16'h0000, 16'(polls));
    $display("test_answer done");
  endtask
  task automatic test_line_rx;
    @(posedge mclk);
    #1 line_rx_data = 8'ha5;
    line_rx_valid = 1'b1;
    for (int i = 0; i < 100; i++) begin
      @(posedge mclk);
      if (line_rx_ready === 1'b1) break;
    end
    #1 line_rx_valid = 1'b0;
    for (int i = 0; i < 12 * BIT && smc_host_model_i.rx_q.size() == 0; i++) @(posedge mclk);
    chk("line to host", 16'h01a5,
      {7'h0, smc_host_model_i.rx_q.size() == 1, smc_host_model_i.rx_q[0]});
    $display("test_line_rx done");
  endtask
  task automatic test_escape;
    send_str("+++");
    repeat (40) @(posedge mclk);
    #1;
    chk("line byte count", 16'h0003, 16'(lt_q.size()));
    for (int i = 0; i < 3; i++) chk("host to line", 16'h002b, lt_q[i]);
    chk("online command", 16'h0001, {14'h0, mode_data, host_dcd});
    chk("clear to send", 16'h0003, {14'h0, cts_lo != 0, host_cts});
    $display("test_escape done");
  endtask
  task automatic test_done;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    sys_rst = 1'b1;
    line_tx_ready = 1'b0;
    line_rx_valid = 1'b0;
    line_rx_data = 8'h00;
    chip_ring = 1'b0;
    chip_phase_done = 1'b0;
    chip_phase_fail = 1'b0;
    fails = 0;
    checked = 0;
    cts_lo = 0;
    polls = 0;
    repeat (2) @(posedge mclk);
    #1 sys_rst = 1'b0;
    test_reset;
    test_answer;
    test_line_rx;
    test_escape;
    test_done;
  end
  // Eight serial frames take about 104k cycles
  initial begin
    repeat (115000) @(posedge mclk);
    fails++;
    $display("Error watchdog expected end seen timeout");
    test_done;
  end
endmodule
`default_nettype wire

// file: testbench/smc_host_model.sv
// Host terminal model: 8N1 serial sender and receiver paced by clear-to-send
`include "smc_map.vh"
`default_nettype none
module smc_host_model (
  input wire logic mclk,
  input wire logic host_txd,
  input wire logic host_cts,
  output var logic host_rxd,
  output var logic host_rts
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BIT = `SMC_BIT_CYC;
  logic [7:0] rx_q[$];
  logic [7:0] rx_byte;
  // Idle line is marking; the terminal is always ready to take bytes
  initial begin
    host_rxd = 1'b1;
    host_rts = 1'b1;
  end
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    @(posedge mclk);
    while (host_cts !== 1'b1) @(posedge mclk);
    for (int i = 0; i < 10; i++) begin
      #1 host_rxd = frame[i];
      repeat (BIT) @(posedge mclk);
    end
  endtask
  // Mid-bit sampling; a frame with a bad stop bit is thrown away
  initial begin
    forever begin
      @(negedge host_txd);
      repeat (BIT / 2) @(posedge mclk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge mclk);
        rx_byte[i] = host_txd;
      end
      repeat (BIT) @(posedge mclk);
      if (host_txd === 1'b1) rx_q.push_back(rx_byte);
    end
  end
endmodule
`default_nettype wire
